// file: aicp_device.sv
`timescale 1ns/10ps
// How it works
// - analog cfg bit7 set selects parallel load
// - parallel-load bit resets to zero
// - analog cfg bit1 picks input channel
// - gains set directly from register fields
// - digital boost independent of volume
// - host sets boost before unmuting
// - host picks smallest adequate analog gain
// - address 110110x, x strap latched once
// - strap low 1101100, high 1101101
// - works at 100 and 400 kHz
// - slave only, never stretches clock
// - bytes msb first, each acknowledged except the last read byte
// - master changes data only clock low
// - ack holds data low whole period
// - master waits for address ack
// - any byte count, stop ends
// - write: addr, reg, data, all acked
// - read: set reg, restart, return data
// - master nacks read byte then stops
// - port active only when gain straps high
module aicp_device
   import aicp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       ce_i,
   input  wire logic       low_power_addr_strap_i,
   input  wire logic [1:0] gain_strap_i,
   aicp_if.dev             bus,
   output logic            parallel_load_mode_o,
   output logic            chan_sel_o,
   output logic [1:0]      analog_path_gain_o,
   output logic [1:0]      digital_path_gain_o,
   output logic [7:0]      volume_left_o,
   output logic [7:0]      volume_right_o
);
   import aicp_pkg::*;
   typedef enum logic [4:0] {
      AICP_IDLE = 5'h01,
      AICP_ADDR = 5'h02,
      AICP_ACK  = 5'h04,
      AICP_RX   = 5'h08,
      AICP_TX   = 5'h10
   } aicp_dev_state_t;
   // ===========================================
   // synchronisers and strap capture
   logic scl_s;
   logic sda_s;
   logic strap_s;
   logic gs0_s;
   logic gs1_s;
   aicp_sync u_scl (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                    .d_i(bus.scl), .q_o(scl_s));
   aicp_sync u_sda (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                    .d_i(bus.sda), .q_o(sda_s));
   aicp_sync u_strap (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                      .d_i(low_power_addr_strap_i), .q_o(strap_s));
   aicp_sync u_g0 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                   .d_i(gain_strap_i[0]), .q_o(gs0_s));
   aicp_sync u_g1 (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                   .d_i(gain_strap_i[1]), .q_o(gs1_s));

   logic [1:0] cap_cnt_reg;
   logic       addr_x_reg;
   logic       active_reg;
   // strap taken once the synchroniser is filled after release
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cap_cnt_reg <= 2'h0;
         addr_x_reg  <= 1'b0;
      end else if (ce_i && cap_cnt_reg != 2'h3) begin
         cap_cnt_reg <= cap_cnt_reg + 2'h1;
         if (cap_cnt_reg == 2'h2) begin
            addr_x_reg <= strap_s;
         end
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         active_reg <= 1'b0;
      end else if (ce_i) begin
         active_reg <= gs0_s & gs1_s;
      end
   end
   // ===========================================
   // line event detection
   logic scl_d_reg;
   logic sda_d_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else if (ce_i) begin
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
      end
   end
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   assign scl_rise = scl_s & ~scl_d_reg;
   assign scl_fall = ~scl_s & scl_d_reg;
   assign start_ev = active_reg & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_ev  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
   // ===========================================
   // protocol engine
   aicp_dev_state_t state_reg;
   logic [7:0]      shift_reg;
   logic [3:0]      bit_cnt_reg;
   logic [1:0]      byte_idx_reg;  // 0 addr, 1 reg, 2+ data
   logic            rd_reg;
   logic            acked_reg;     // slot acked: by us, or by the master on a read byte
   logic [7:0]      ptr_reg;
   logic            sda_low_reg;
   logic [7:0]      analog_cfg_reg;
   logic [7:0]      digital_cfg_reg;
   logic [7:0]      vol_l_reg;
   logic [7:0]      vol_r_reg;
   logic [7:0]      rd_data;
   logic [6:0]      own_addr;
   assign own_addr = {SLV_ADDR_HI, addr_x_reg};

   always_comb begin
      unique case (ptr_reg)
         ANALOG_CFG_OFS:  rd_data = analog_cfg_reg;
         DIGITAL_CFG_OFS: rd_data = digital_cfg_reg;
         VOLUME_L_OFS:    rd_data = vol_l_reg;
         VOLUME_R_OFS:    rd_data = vol_r_reg;
         default:         rd_data = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg       <= AICP_IDLE;
         shift_reg       <= 8'h00;
         bit_cnt_reg     <= 4'h0;
         byte_idx_reg    <= 2'h0;
         rd_reg          <= 1'b0;
         acked_reg       <= 1'b0;
         ptr_reg         <= 8'h00;
         sda_low_reg     <= 1'b0;
         analog_cfg_reg  <= ANALOG_CFG_RST & ~(8'h01 << PLM_BIT);
         digital_cfg_reg <= DIGITAL_CFG_RST;
         vol_l_reg       <= VOLUME_RST;
         vol_r_reg       <= VOLUME_RST;
      end else if (ce_i) begin
         if (!active_reg || stop_ev) begin
            state_reg   <= AICP_IDLE;
            sda_low_reg <= 1'b0;
         end else if (start_ev) begin
            state_reg    <= AICP_ADDR;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'h0;
            sda_low_reg  <= 1'b0;
         end else begin
            unique case (state_reg)
               AICP_IDLE: begin
                  sda_low_reg <= 1'b0;
               end
               AICP_ADDR, AICP_RX: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                     bit_cnt_reg <= 4'h0;
                     state_reg   <= AICP_ACK;
                     acked_reg   <= 1'b1;
                     sda_low_reg <= 1'b1;
                     if (state_reg == AICP_ADDR) begin
                        rd_reg <= shift_reg[0];
                        if (shift_reg[7:1] != own_addr) begin
                           state_reg   <= AICP_IDLE;
                           sda_low_reg <= 1'b0;
                        end
                     end else if (byte_idx_reg == 2'h1) begin
                        ptr_reg <= shift_reg;
                     end else begin
                        unique case (ptr_reg)
                           ANALOG_CFG_OFS:  analog_cfg_reg  <= shift_reg;
                           DIGITAL_CFG_OFS: digital_cfg_reg <= shift_reg;
                           VOLUME_L_OFS:    vol_l_reg       <= shift_reg;
                           VOLUME_R_OFS:    vol_r_reg       <= shift_reg;
                           default:         ;
                        endcase
                        ptr_reg <= ptr_reg + 8'h01;
                     end
                  end
               end
               AICP_ACK: begin
                  if (scl_fall) begin
                     sda_low_reg <= 1'b0;
                     if (byte_idx_reg != 2'h3) begin
                        byte_idx_reg <= byte_idx_reg + 2'h1;
                     end
                     if (acked_reg && rd_reg) begin
                        state_reg   <= AICP_TX;
                        shift_reg   <= rd_data;
                        sda_low_reg <= ~rd_data[7];
                        bit_cnt_reg <= 4'h1;
                     end else if (acked_reg) begin
                        state_reg <= AICP_RX;
                     end else begin
                        state_reg <= AICP_IDLE;
                     end
                  end
               end
               AICP_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_reg == 4'h8) begin
                        sda_low_reg <= 1'b0;
                        state_reg   <= AICP_ACK;
                        acked_reg   <= 1'b0;
                        ptr_reg     <= ptr_reg + 8'h01;
                     end else begin
                        sda_low_reg <= ~shift_reg[6];
                        shift_reg   <= {shift_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
            endcase
            // master ack during read keeps streaming
            if (state_reg == AICP_ACK && !acked_reg && scl_rise) begin
               acked_reg <= ~sda_s;
            end
         end
      end
   end
   // ===========================================
   // outputs; sda is never used to hold scl
   assign bus.sda_dev_o    = 1'b0;
   assign bus.sda_dev_oe_n = ~sda_low_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         parallel_load_mode_o <= 1'b0;
         chan_sel_o           <= 1'b0;
         analog_path_gain_o   <= 2'h0;
         digital_path_gain_o  <= 2'h0;
         volume_left_o        <= 8'h00;
         volume_right_o       <= 8'h00;
      end else if (ce_i) begin
         parallel_load_mode_o <= analog_cfg_reg[PLM_BIT];
         chan_sel_o           <= analog_cfg_reg[CHSEL_BIT];
         analog_path_gain_o   <= analog_cfg_reg[AGAIN_LSB +: 2];
         digital_path_gain_o  <= digital_cfg_reg[DBOOST_LSB +: 2];
         volume_left_o        <= vol_l_reg;
         volume_right_o       <= vol_r_reg;
      end
   end
endmodule

// file: aicp_host.sv
`timescale 1ns/10ps
module aicp_host
   import aicp_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire logic       ce_i,
   input  wire logic       fast_i,
   input  wire logic [1:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic [7:0]      rdata_o,
   aicp_if.host            bus,
   input  wire logic       addr_x_i
);
   import aicp_pkg::*;
   typedef enum logic [3:0] {
      AICPH_IDLE = 4'h1,
      AICPH_BIT  = 4'h2,
      AICPH_STOP = 4'h4,
      AICPH_RSTA = 4'h8
   } aicp_host_state_t;
   logic sda_s;
   aicp_sync u_sda (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
                    .d_i(bus.sda), .q_o(sda_s));
   // ===========================================
   // command registers
   logic [7:0] reg_addr_reg;
   logic [7:0] data_reg;
   logic       go;
   logic       is_read_reg;
   logic       busy_reg;
   logic       nack_reg;
   assign go = wr_i && addr_i == HC_CTRL_OFS && wdata_i[0] && !busy_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         reg_addr_reg <= 8'h00;
         is_read_reg  <= 1'b0;
         rdata_o      <= 8'h00;
      end else if (ce_i) begin
         if (wr_i && addr_i == HC_REG_OFS) reg_addr_reg <= wdata_i;
         if (go) is_read_reg <= wdata_i[1];
         if (rd_i) begin
            unique case (addr_i)
               HC_DATA_OFS: rdata_o <= data_reg;
               HC_STAT_OFS: rdata_o <= {6'h00, nack_reg, busy_reg};
               default:     rdata_o <= 8'h00;
            endcase
         end
      end
   end
   // ===========================================
   // bit engine: four quarter phases per bit
   aicp_host_state_t state_reg;
   logic [5:0] div_reg;
   logic [1:0] ph_reg;
   logic [3:0] bit_reg;
   logic [1:0] seg_reg;   // 0 addr w,1 reg,2 data/addr r,3 read data
   logic [7:0] tx_reg;
   logic       scl_low_reg;
   logic       sda_low_reg;
   logic       tick;
   assign tick = div_reg == 6'h0;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_reg <= 6'h0;
      end else if (ce_i) begin
         div_reg <= tick ? ((fast_i ? QTR_400K : QTR_100K) - 6'h1) : div_reg - 6'h1;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg   <= AICPH_IDLE;
         ph_reg      <= 2'h0;
         bit_reg     <= 4'h0;
         seg_reg     <= 2'h0;
         tx_reg      <= 8'h00;
         scl_low_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         busy_reg    <= 1'b0;
         nack_reg    <= 1'b0;
         data_reg    <= 8'h00;
      end else if (ce_i) begin
         if (wr_i && addr_i == HC_DATA_OFS && !busy_reg) data_reg <= wdata_i;
         if (go) begin
            busy_reg    <= 1'b1;
            nack_reg    <= 1'b0;
            state_reg   <= AICPH_BIT;
            sda_low_reg <= 1'b1;          // start
            ph_reg      <= 2'h0;
            bit_reg     <= 4'h0;
            seg_reg     <= 2'h0;
            tx_reg      <= {SLV_ADDR_HI, addr_x_i, 1'b0};
         end else if (tick && state_reg != AICPH_IDLE) begin
            ph_reg <= ph_reg + 2'h1;
            unique case (state_reg)
               AICPH_BIT: begin
                  unique case (ph_reg)
                     2'h0: begin
                        scl_low_reg <= 1'b1;
                     end
                     2'h1: begin
                        if (bit_reg < 4'h8) begin
                           sda_low_reg <= (seg_reg == 2'h3) ? 1'b0 : ~tx_reg[7];
                        end else begin
                           sda_low_reg <= 1'b0;
                        end
                     end
                     2'h2: begin
                        scl_low_reg <= 1'b0;
                     end
                     2'h3: begin
                        if (bit_reg < 4'h8) begin
                           tx_reg  <= {tx_reg[6:0], 1'b0};
                           if (seg_reg == 2'h3) data_reg <= {data_reg[6:0], sda_s};
                           bit_reg <= bit_reg + 4'h1;
                        end else begin
                           bit_reg <= 4'h0;
                           if (seg_reg != 2'h3 && sda_s) begin
                              nack_reg  <= 1'b1;
                              state_reg <= AICPH_STOP;
                           end else if (seg_reg == 2'h0) begin
                              seg_reg <= 2'h1;
                              tx_reg  <= reg_addr_reg;
                           end else if (seg_reg == 2'h1 && is_read_reg) begin
                              state_reg <= AICPH_RSTA;
                           end else if (seg_reg == 2'h1) begin
                              seg_reg <= 2'h2;
                              tx_reg  <= data_reg;
                           end else if (seg_reg == 2'h2 && is_read_reg) begin
                              seg_reg <= 2'h3;
                           end else begin
                              state_reg <= AICPH_STOP;
                           end
                        end
                     end
                  endcase
               end
               AICPH_RSTA: begin
                  unique case (ph_reg)
                     2'h0: scl_low_reg <= 1'b1;
                     2'h1: sda_low_reg <= 1'b0;
                     2'h2: scl_low_reg <= 1'b0;
                     2'h3: begin
                        sda_low_reg <= 1'b1;
                        state_reg   <= AICPH_BIT;
                        seg_reg     <= 2'h2;
                        tx_reg      <= {SLV_ADDR_HI, addr_x_i, 1'b1};
                     end
                  endcase
               end
               AICPH_STOP: begin
                  unique case (ph_reg)
                     2'h0: scl_low_reg <= 1'b1;
                     2'h1: sda_low_reg <= 1'b1;
                     2'h2: scl_low_reg <= 1'b0;
                     2'h3: begin
                        sda_low_reg <= 1'b0;
                        state_reg   <= AICPH_IDLE;
                        busy_reg    <= 1'b0;
                     end
                  endcase
               end
               default: state_reg <= AICPH_IDLE;
            endcase
         end
      end
   end
   assign bus.scl_o         = 1'b0;
   assign bus.scl_oe_n      = ~scl_low_reg;
   assign bus.sda_host_o    = 1'b0;
   assign bus.sda_host_oe_n = ~sda_low_reg;
endmodule

// file: aicp_if.sv
`timescale 1ns/10ps
interface aicp_if;
   logic scl_o;
   logic scl_oe_n;
   logic sda_dev_o;
   logic sda_dev_oe_n;
   logic sda_host_o;
   logic sda_host_oe_n;
   wire  scl  = scl_oe_n ? 1'b1 : scl_o;
   wire  sda  = (sda_dev_oe_n ? 1'b1 : sda_dev_o) & (sda_host_oe_n ? 1'b1 : sda_host_o);
   modport dev (input scl, input sda, output sda_dev_o, output sda_dev_oe_n);
   modport host (input scl, input sda, output scl_o, output scl_oe_n,
                 output sda_host_o, output sda_host_oe_n);
endinterface

// file: aicp_pkg.sv
package aicp_pkg;
   // ===========================================
   // bus addressing
   localparam logic [5:0] SLV_ADDR_HI      = 6'h36;  // 110110
   localparam logic [7:0] ANALOG_CFG_OFS   = 8'h06;
   localparam logic [7:0] ANALOG_CFG_RST   = 8'h51;
   localparam int         PLM_BIT          = 7;
   localparam int         CHSEL_BIT        = 1;
   localparam int         AGAIN_LSB        = 2;
   localparam logic [7:0] DIGITAL_CFG_OFS  = 8'h02;
   localparam logic [7:0] DIGITAL_CFG_RST  = 8'h14;
   localparam logic [7:0] VOLUME_L_OFS     = 8'h04;
   localparam logic [7:0] VOLUME_R_OFS     = 8'h05;
   localparam logic [7:0] VOLUME_RST       = 8'hcf;
   localparam int         DBOOST_LSB       = 4;
   // ===========================================
   // host command port
   localparam logic [1:0] HC_CTRL_OFS   = 2'h0; // w: bit0 go, bit1 read
   localparam logic [1:0] HC_REG_OFS    = 2'h1; // w: register address
   localparam logic [1:0] HC_DATA_OFS   = 2'h2; // w: write data, r: read data
   localparam logic [1:0] HC_STAT_OFS   = 2'h3; // r: bit0 busy, bit1 nack
   // ===========================================
   // timing: 10 MHz system clock, bus clock by divider
   localparam int         CLK_NS        = 100;
   localparam int         SCL_100K_NS   = 10000;
   localparam int         SCL_400K_NS   = 2500;
   localparam logic [5:0] QTR_100K      = 6'(SCL_100K_NS / CLK_NS / 4);
   localparam logic [5:0] QTR_400K      = 6'(SCL_400K_NS / CLK_NS / 4);
   localparam logic [1:0] HC_RATE_OFS   = 2'h1; // reserved for symmetry
endpackage

// file: aicp_properties.sv
`timescale 1ns/10ps
module aicp_properties (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic scl_o,
   input wire logic scl_oe_n,
   input wire logic sda_dev_o,
   input wire logic sda_dev_oe_n,
   input wire logic sda_host_o,
   input wire logic sda_host_oe_n,
   input wire logic scl,
   input wire logic sda
);
   // ===========================================
   // frame tracking: bit count, first byte, read phase
   logic       scl_q;
   logic       sda_q;
   logic       fb;
   logic       rd_ph;
   logic [3:0] cnt;
   wire        st = scl && scl_q && sda_q && !sda;
   wire        sp = scl && scl_q && !sda_q && sda;
   wire        sr = scl && !scl_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt   <= 4'h0;
         fb    <= 1'b0;
         rd_ph <= 1'b0;
      end else if (st) begin
         cnt   <= 4'h0;
         fb    <= 1'b1;
         rd_ph <= 1'b0;
      end else if (sr) begin
         cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
         if (cnt == 4'h9) fb <= 1'b0;
         if (fb && cnt == 4'h7) rd_ph <= sda;
      end
   end
   // ===========================================
   // properties
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence scl_hold;
      scl [*8];
   endsequence
   sequence bus_free;
      (scl && sda) [*3];
   endsequence
   a_dev_pull_zero: assert property (!sda_dev_oe_n |-> !sda_dev_o)
      else $error("device drives sda high");
   a_dev_stable_high: assert property (scl && $past(scl) |-> $stable(sda_dev_oe_n))
      else $error("device changed sda while scl high");
   a_write_ack_only: assert property (sr && !sda_dev_oe_n && !rd_ph |-> cnt == 4'h8)
      else $error("device pulled sda outside ack slot");
   a_read_nack_free: assert property (sr && rd_ph && !fb && cnt == 4'h8 |-> sda_dev_oe_n)
      else $error("device held master ack slot");
   a_scl_high_min: assert property ($rose(scl) |-> scl_hold)
      else $error("scl high phase too short");
   a_scl_low_max: assert property ($fell(scl) |-> ##[1:120] scl)
      else $error("scl held low too long");
   a_start_clocks: assert property (st |-> ##[1:120] !scl)
      else $error("no clock after start");
   a_stop_release: assert property (sp |-> (sda_dev_oe_n && sda_host_oe_n) ##0 bus_free)
      else $error("bus not released after stop");
   a_scl_host_only: assert property (!scl |-> !scl_oe_n && !scl_o)
      else $error("scl low without host pull");
endmodule

// file: aicp_sync.sv
`timescale 1ns/10ps
module aicp_sync (
   input  wire logic clk_i,
   input  wire logic sys_rst_i,
   input  wire logic ce_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta_reg;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_reg <= 1'b1;
         q_o      <= 1'b1;
      end else if (ce_i) begin
         meta_reg <= d_i;
         q_o      <= meta_reg;
      end
   end
endmodule

// file: amp_i2c_control_port_tb_top.sv
`timescale 1ns/10ps
module amp_i2c_control_port_tb_top;
   import aicp_pkg::*;
   typedef struct packed {
      logic [7:0] exp;
      logic [7:0] msk;
   } aicp_note_t;
   logic       clk_i;
   logic       sys_rst_i;
   logic       fast_i;
   logic [1:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic       addr_x_i;
   logic       strap_i;
   logic [1:0] gstrap_i;
   logic       plm_o;
   logic       chs_o;
   logic [1:0] ag_o;
   logic [1:0] dg_o;
   logic [7:0] vl_o;
   logic [7:0] vr_o;
   logic       rd_q;
   logic [7:0] sh;
   logic [7:0] sa6;
   logic [7:0] sa2;
   logic [7:0] svol;
   int         nb;
   int         n_mismatch;
   int         checks;
   int         seed;
   aicp_note_t notes[$];
   aicp_note_t nt;
   aicp_if aicp_if_i ();
   aicp_device aicp_device_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .low_power_addr_strap_i(strap_i), .gain_strap_i(gstrap_i), .bus(aicp_if_i),
      .parallel_load_mode_o(plm_o), .chan_sel_o(chs_o), .analog_path_gain_o(ag_o),
      .digital_path_gain_o(dg_o), .volume_left_o(vl_o), .volume_right_o(vr_o));
   aicp_host aicp_host_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
      .fast_i(fast_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .bus(aicp_if_i), .addr_x_i(addr_x_i));
   aicp_properties aicp_properties_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .scl_o(aicp_if_i.scl_o), .scl_oe_n(aicp_if_i.scl_oe_n),
      .sda_dev_o(aicp_if_i.sda_dev_o), .sda_dev_oe_n(aicp_if_i.sda_dev_oe_n),
      .sda_host_o(aicp_if_i.sda_host_o), .sda_host_oe_n(aicp_if_i.sda_host_oe_n),
      .scl(aicp_if_i.scl), .sda(aicp_if_i.sda));
   // ===========================================
   // clock, compare, verdict
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ===========================================
   // read-data and wire monitors
   always @(posedge clk_i) begin
      rd_q <= rd_i;
      if (rd_q === 1'b1 && notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt.msk !== 8'h00) chk("rdata", nt.exp, rdata_o & nt.msk);
      end
   end
   always @(negedge aicp_if_i.sda) if (aicp_if_i.scl === 1'b1) nb = 0;
   always @(posedge aicp_if_i.scl) begin
      sh = {sh[6:0], aicp_if_i.sda};
      nb = nb + 1;
      if (nb == 8) chk("wire_addr", {SLV_ADDR_HI, addr_x_i, 1'b0}, {sh[7:1], 1'b0});
   end
   // ===========================================
   // register port tasks
   task automatic hw(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic hr(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      notes.push_back(aicp_note_t'{e, m});
      @(posedge clk_i);
      rd_i <= 1'b0;
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 3000; k++) begin
         hr(HC_STAT_OFS, 8'h00, 8'h00);
         #1;
         if (rdata_o[0] === 1'b0) break;
      end
   endtask
   task automatic wr_reg(input logic [7:0] r, input logic [7:0] v, input logic nk);
      hw(HC_REG_OFS, r);
      hw(HC_DATA_OFS, v);
      hw(HC_CTRL_OFS, 8'h01);
      wait_idle();
      hr(HC_STAT_OFS, {6'h00, nk, 1'b0}, 8'h03);
   endtask
   task automatic rd_reg(input logic [7:0] r, input logic [7:0] v);
      hw(HC_REG_OFS, r);
      hw(HC_CTRL_OFS, 8'h03);
      wait_idle();
      hr(HC_DATA_OFS, v, 8'hff);
   endtask
   task automatic chk_out();
      chk("parallel_load", {7'h00, sa6[PLM_BIT]}, {7'h00, plm_o});
      chk("chan_sel", {7'h00, sa6[CHSEL_BIT]}, {7'h00, chs_o});
      chk("analog_gain", {6'h00, sa6[AGAIN_LSB+:2]}, {6'h00, ag_o});
      chk("digital_gain", {6'h00, sa2[DBOOST_LSB+:2]}, {6'h00, dg_o});
      chk("volume_left", svol, vl_o);
      chk("volume_right", svol, vr_o);
   endtask
   // ===========================================
   // main sequence
   initial begin
      seed = 32'ha1b23fc7;
      {n_mismatch, checks, nb, rd_q, sh} = '0;
      {sys_rst_i, fast_i, addr_i, wdata_i, wr_i, rd_i} = {1'b1, 13'h0000};
      {addr_x_i, strap_i, gstrap_i} = 4'h3;
      for (int s = 0; s < 2; s++) begin
         sys_rst_i <= 1'b1;
         strap_i   <= s[0];
         addr_x_i  <= s[0];
         repeat (20) @(posedge clk_i);
         sys_rst_i <= 1'b0;
         repeat (5) @(posedge clk_i);
         strap_i <= ~s[0];
         repeat (10) @(posedge clk_i);
         {sa6, sa2, svol} = {ANALOG_CFG_RST, DIGITAL_CFG_RST, VOLUME_RST};
         chk_out();
         rd_reg(ANALOG_CFG_OFS, ANALOG_CFG_RST);
         for (int f = 0; f < 2; f++) begin
            fast_i <= f[0];
            sa6 = 8'($random(seed));
            sa6[PLM_BIT] = ~f[0];
            wr_reg(ANALOG_CFG_OFS, sa6, 1'b0);
            rd_reg(ANALOG_CFG_OFS, sa6);
            sa2 = 8'($random(seed));
            wr_reg(DIGITAL_CFG_OFS, sa2, 1'b0);
            svol = 8'($random(seed));
            wr_reg(VOLUME_L_OFS, svol, 1'b0);
            wr_reg(VOLUME_R_OFS, svol, 1'b0);
            chk_out();
         end
         addr_x_i <= ~s[0];
         wr_reg(ANALOG_CFG_OFS, ~sa6, 1'b1);
         addr_x_i <= s[0];
         gstrap_i <= 2'b01;
         wr_reg(ANALOG_CFG_OFS, ~sa6, 1'b1);
         gstrap_i <= 2'b11;
         rd_reg(ANALOG_CFG_OFS, sa6);
         chk_out();
         // last read result must be compared before reset clears it
         repeat (2) @(posedge clk_i);
      end
      give_verdict();
   end
   initial begin
      repeat (80000) @(posedge clk_i);
      n_mismatch++;
      give_verdict();
   end
endmodule
